/* File: fgpm_regs.svh */
`ifndef FGPM_REGS_SVH
`define FGPM_REGS_SVH
// Operation
// RL1 - After power-up the controller starts in the active state.
// RL2 - In the active state measurement and estimation run continuously.
// RL3 - In sleep, measurement and estimation stop while register contents are kept.
// RL4 - With bus-low sleep enabled, both lines low for the idle time puts the device to sleep.
// RL5 - Bus-low sleep ends as soon as either line is high.
// RL6 - With undervoltage sleep enabled, low cell voltage plus a steady bus for the idle time sleeps. The code sleeps only with both lines low or both high.
// RL7 - Undervoltage sleep ends on any level change of either line.
// RL8 - The host releases the bus high before a START to wake bus-low sleep.
// RL9 - After undervoltage sleep entered with the bus low, the host releases the bus first.
// RL10 - After undervoltage sleep entered with the bus high, a START is accepted directly.
// RL11 - A host powering up on a charger sends START, STOP, START to wake either sleep.
// RL12 - A host wanting bus-low sleep holds the bus low beyond the longest idle time.
// RL13 - The host keeps clock low periods shorter than the idle time in normal transfers.
// RL14 - With a charger that never drives the bus, the device stays asleep and does not measure.
// RL15 - Idle time is counted on the time base and restarts on any change of either line.
`define FGPM_CLK_HZ         10000000
`define FGPM_IDLE_SLEEP_MS  2000
`define FGPM_IDLE_CYCLES    ((`FGPM_CLK_HZ / 1000) * `FGPM_IDLE_SLEEP_MS)
`define FGPM_CNT_W          32
`endif

/* File: fgpm_pkg.sv */
package fgpm_pkg;
    typedef enum logic [1:0] {
        FGPM_ACTIVE   = 2'b00,
        FGPM_SLEEP_BL = 2'b01,
        FGPM_SLEEP_UV = 2'b10
    } fgpm_state_t;
endpackage

/* File: fgpm_bus_if.sv */
`timescale 1ns/1ps
interface fgpm_bus_if;
    logic sda;
    logic scl;
    logic change;
    logic clear;
    logic idle_done;
    modport ctl (input sda, input scl, input change, input idle_done, output clear);
    modport mon (output sda, output scl, output change, output idle_done, input clear);
endinterface

/* File: fgpm_bus_monitor.sv */
`timescale 1ns/1ps
`include "fgpm_regs.svh"
module fgpm_bus_monitor #(
    parameter int unsigned IDLE_CYCLES = `FGPM_IDLE_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sda_in,
    input  wire logic scl_in,
    fgpm_bus_if.mon   bus
);
    // Limit must sit above the restart cycle
    if (IDLE_CYCLES < 2) begin : g_idle_check
        $error("IDLE_CYCLES too small");
    end
    logic [2:0]               sda_sync_reg;
    logic [2:0]               scl_sync_reg;
    logic                     sda_reg;
    logic                     scl_reg;
    logic [`FGPM_CNT_W-1:0]   cnt_reg;
    logic                     done_reg;
    // Third stage agreeing with second filters a metastable first stage
    wire sda_agree = sda_sync_reg[1] == sda_sync_reg[2];
    wire scl_agree = scl_sync_reg[1] == scl_sync_reg[2];
    wire sda_new   = sda_agree ? sda_sync_reg[2] : sda_reg;
    wire scl_new   = scl_agree ? scl_sync_reg[2] : scl_reg;
    wire changed   = (sda_new != sda_reg) || (scl_new != scl_reg);
    wire [`FGPM_CNT_W-1:0] cnt_next = cnt_reg + `FGPM_CNT_W'h1;
    wire at_limit  = cnt_reg >= `FGPM_CNT_W'(IDLE_CYCLES - 1);
    // Pins have pull-downs, so reset as low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_sync_reg <= 3'h0;
            scl_sync_reg <= 3'h0;
            sda_reg      <= 1'b0;
            scl_reg      <= 1'b0;
        end else begin
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_reg      <= sda_new;
            scl_reg      <= scl_new;
        end
    end
    // RL15 restart on edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else if (changed || bus.clear) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else if (!at_limit) begin
            cnt_reg  <= cnt_next;
        end else begin
            done_reg <= 1'b1;
        end
    end
    assign bus.sda       = sda_reg;
    assign bus.scl       = scl_reg;
    assign bus.change    = changed;
    assign bus.idle_done = done_reg;
    property p_idle_restart;
        @(posedge clk) disable iff (!rst_n) changed |=> !done_reg && cnt_reg == '0;
    endproperty
    a_idle_restart: assert property (p_idle_restart) else $error("idle count not restarted"); // RL15
endmodule

/* File: fgpm_power_ctrl.sv */
`timescale 1ns/1ps
`include "fgpm_regs.svh"
module fgpm_power_ctrl
    import fgpm_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = `FGPM_IDLE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sda_in,
    input  wire logic       scl_in,
    input  wire logic       sleep_on_bus_low_enable,
    input  wire logic       sleep_on_undervoltage_enable,
    input  wire logic       cell_below_sleep_threshold,
    output logic            measure_enable,
    output logic            sleeping,
    output logic            start_ready,
    output fgpm_pkg::fgpm_state_t power_state
);
    import fgpm_pkg::*;
    fgpm_bus_if bus ();
    fgpm_bus_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) u_mon (
        .clk    (clk),
        .rst_n  (rst_n),
        .sda_in (sda_in),
        .scl_in (scl_in),
        .bus    (bus)
    );
    fgpm_state_t state_reg;
    fgpm_state_t state_next;
    logic        uv_bus_high_reg;
    logic        uv_bus_high_next;
    logic        meas_reg;
    logic        sleep_reg;
    logic        ready_reg;

    if (IDLE_CYCLES < 2) begin : g_idle_check
        $error("IDLE_CYCLES too small");
    end

    // Shared decode of the awake state
    function automatic logic is_active(input fgpm_state_t s);
        return s == FGPM_ACTIVE;
    endfunction

    wire bus_low  = !bus.sda && !bus.scl;
    wire bus_high = bus.sda && bus.scl;
    wire bus_any_high = bus.sda || bus.scl;
    // RL4 both lines low long enough
    wire go_bl = sleep_on_bus_low_enable && bus_low && bus.idle_done && !bus.change;
    // RL6 steady bus and low cell
    wire go_uv = sleep_on_undervoltage_enable && cell_below_sleep_threshold
                 && (bus_low || bus_high) && bus.idle_done && !bus.change;
    // Idle count parked in sleep, saves toggling
    assign bus.clear = sleep_reg;
    always_comb begin
        state_next       = state_reg;
        uv_bus_high_next = uv_bus_high_reg;
        case (state_reg)
            FGPM_ACTIVE: begin
                if (go_bl) begin
                    state_next = FGPM_SLEEP_BL;
                end else if (go_uv) begin
                    state_next       = FGPM_SLEEP_UV;
                    uv_bus_high_next = bus_high;
                end
            end
            // RL5 wake on any high; RL14 stays while lines low
            FGPM_SLEEP_BL: begin
                if (bus_any_high) state_next = FGPM_ACTIVE;
            end
            // RL7 wake on any change
            FGPM_SLEEP_UV: begin
                if (bus.change) state_next = FGPM_ACTIVE;
            end
            default: state_next = FGPM_ACTIVE;
        endcase
    end
    // RL1 active after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= FGPM_ACTIVE;
            uv_bus_high_reg <= 1'b0;
        end else begin
            state_reg       <= state_next;
            uv_bus_high_reg <= uv_bus_high_next;
        end
    end

    // RL2 RL3 measure and sleep flags from the next state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_reg  <= 1'b1;
            sleep_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            meas_reg  <= is_active(state_next);
            sleep_reg <= !is_active(state_next);
            // RL10 start taken directly
            ready_reg <= is_active(state_next)
                         || (state_next == FGPM_SLEEP_UV && uv_bus_high_next);
        end
    end
    assign measure_enable = meas_reg;
    assign sleeping       = sleep_reg;
    assign start_ready    = ready_reg;
    assign power_state    = state_reg;

    // Assertion helper, counted apart from the monitor
    logic [`FGPM_CNT_W-1:0] steady_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            steady_reg <= '0;
        end else if (bus.change) begin
            steady_reg <= '0;
        end else if (steady_reg != '1) begin
            steady_reg <= steady_reg + `FGPM_CNT_W'h1;
        end
    end

    sequence s_bl_asleep;
        state_reg == FGPM_SLEEP_BL;
    endsequence
    sequence s_awake;
        state_reg == FGPM_ACTIVE ##1 meas_reg;
    endsequence
    sequence s_bl_entry;
        state_reg == FGPM_ACTIVE ##1 s_bl_asleep;
    endsequence
    sequence s_uv_entry;
        state_reg == FGPM_ACTIVE ##1 state_reg == FGPM_SLEEP_UV;
    endsequence

    property p_bl_wake;
        @(posedge clk) disable iff (!rst_n) s_bl_asleep ##0 bus_any_high |=> s_awake;
    endproperty
    a_bl_wake: assert property (p_bl_wake) else $error("bus-low sleep not left"); // RL5
    property p_uv_wake;
        @(posedge clk) disable iff (!rst_n)
            state_reg == FGPM_SLEEP_UV && bus.change |=> s_awake;
    endproperty
    a_uv_wake: assert property (p_uv_wake) else $error("uv sleep not left"); // RL7
    property p_bl_enter;
        @(posedge clk) disable iff (!rst_n) state_reg == FGPM_ACTIVE && go_bl |=> s_bl_asleep;
    endproperty
    a_bl_enter: assert property (p_bl_enter) else $error("bus-low sleep not entered"); // RL4
    property p_uv_enter;
        @(posedge clk) disable iff (!rst_n)
            state_reg == FGPM_ACTIVE && go_uv && !go_bl |=> state_reg == FGPM_SLEEP_UV;
    endproperty
    a_uv_enter: assert property (p_uv_enter) else $error("uv sleep not entered"); // RL6
    property p_no_sleep_off;
        @(posedge clk) disable iff (!rst_n)
            state_reg == FGPM_ACTIVE && !sleep_on_bus_low_enable && !sleep_on_undervoltage_enable
            |=> state_reg == FGPM_ACTIVE;
    endproperty
    a_no_sleep_off: assert property (p_no_sleep_off) else $error("sleep while disabled"); // RL1
    property p_meas_active;
        @(posedge clk) disable iff (!rst_n) state_reg == FGPM_ACTIVE |-> meas_reg;
    endproperty
    a_meas_active: assert property (p_meas_active) else $error("measure off when active"); // RL2
    property p_meas_sleep;
        @(posedge clk) disable iff (!rst_n) state_reg != FGPM_ACTIVE |-> !meas_reg && sleep_reg;
    endproperty
    a_meas_sleep: assert property (p_meas_sleep) else $error("measure on in sleep"); // RL3
    property p_stay_low;
        @(posedge clk) disable iff (!rst_n) s_bl_asleep ##0 bus_low |=> s_bl_asleep;
    endproperty
    a_stay_low: assert property (p_stay_low) else $error("woke with bus low"); // RL14
    property p_ready_uv;
        @(posedge clk) disable iff (!rst_n)
            state_reg == FGPM_SLEEP_UV |-> start_ready == uv_bus_high_reg;
    endproperty
    a_ready_uv: assert property (p_ready_uv) else $error("start ready wrong"); // RL10

    property p_idle_gate;
        @(posedge clk) disable iff (!rst_n)
            is_active(state_reg) && !is_active(state_next)
            |-> steady_reg >= `FGPM_CNT_W'(IDLE_CYCLES);
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("sleep before idle time"); // RL15
    property p_uv_hold;
        @(posedge clk) disable iff (!rst_n)
            state_reg == FGPM_SLEEP_UV && !bus.change |=> state_reg == FGPM_SLEEP_UV;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("uv sleep left without change"); // RL7
    property p_ready_active;
        @(posedge clk) disable iff (!rst_n)
            is_active(state_next) |=> start_ready;
    endproperty
    a_ready_active: assert property (p_ready_active) else $error("start not ready awake"); // RL1
    property p_bl_cause;
        @(posedge clk) disable iff (!rst_n)
            s_bl_entry |-> $past(sleep_on_bus_low_enable && bus_low);
    endproperty
    a_bl_cause: assert property (p_bl_cause) else $error("bus-low sleep without cause"); // RL4
    property p_uv_cause;
        @(posedge clk) disable iff (!rst_n)
            s_uv_entry |-> $past(sleep_on_undervoltage_enable && cell_below_sleep_threshold);
    endproperty
    a_uv_cause: assert property (p_uv_cause) else $error("uv sleep without cause"); // RL6
    property p_uv_level;
        @(posedge clk) disable iff (!rst_n)
            s_uv_entry |-> uv_bus_high_reg == $past(bus_high);
    endproperty
    a_uv_level: assert property (p_uv_level) else $error("uv entry level not kept"); // RL10
    property p_bl_not_ready;
        @(posedge clk) disable iff (!rst_n)
            s_bl_asleep |-> !start_ready;
    endproperty
    a_bl_not_ready: assert property (p_bl_not_ready) else $error("ready in bus-low sleep"); // RL10
    property p_meas_steady;
        @(posedge clk) disable iff (!rst_n)
            is_active(state_reg) && !go_bl && !go_uv |=> meas_reg;
    endproperty
    a_meas_steady: assert property (p_meas_steady) else $error("measure dropped awake"); // RL2
    property p_uv_outputs;
        @(posedge clk) disable iff (!rst_n)
            s_uv_entry |-> !meas_reg && sleeping;
    endproperty
    a_uv_outputs: assert property (p_uv_outputs) else $error("uv sleep outputs wrong"); // RL3
    property p_bl_outputs;
        @(posedge clk) disable iff (!rst_n)
            s_bl_entry |-> !meas_reg && sleeping;
    endproperty
    a_bl_outputs: assert property (p_bl_outputs) else $error("bus-low outputs wrong"); // RL3
endmodule

/* File: fgpm_bus_host.sv */
`timescale 1ns/1ps
module fgpm_bus_host (
    input  wire logic clk,
    output logic      sda,
    output logic      scl
);
    logic pullup_on;
    logic sda_low;
    logic scl_low;
    // No pull-up: the device pull-downs take the lines low
    assign sda = pullup_on & ~sda_low;
    assign scl = pullup_on & ~scl_low;
    initial begin
        pullup_on = 1'b1;
        sda_low = 1'b0;
        scl_low = 1'b0;
    end
    task automatic set_lines(input logic pu, input logic s, input logic c);
        @(negedge clk);
        pullup_on <= pu;
        sda_low <= ~s;
        scl_low <= ~c;
    endtask
    task automatic start_stop_start();
        set_lines(1'b1, 1'b1, 1'b1);
        repeat (6) @(negedge clk);
        set_lines(1'b1, 1'b0, 1'b1);
        repeat (6) @(negedge clk);
        set_lines(1'b1, 1'b1, 1'b1);
        repeat (6) @(negedge clk);
        set_lines(1'b1, 1'b0, 1'b1);
        repeat (6) @(negedge clk);
        set_lines(1'b1, 1'b1, 1'b1);
    endtask
endmodule

/* File: fgpm_power_ctrl_tb.sv */
`timescale 1ns/1ps
module fgpm_power_ctrl_tb;
    import fgpm_pkg::*;
    localparam int IDLE = 20;
    logic clk;
    logic rst_n;
    logic sda;
    logic scl;
    logic bl_en;
    logic uv_en;
    logic below;
    logic meas;
    logic slp;
    logic srdy;
    fgpm_state_t st;
    int fails;
    int comparisons;
    fgpm_bus_host host (.clk(clk), .sda(sda), .scl(scl));
    fgpm_power_ctrl #(.IDLE_CYCLES(IDLE)) DUT (
        .clk(clk), .rst_n(rst_n), .sda_in(sda), .scl_in(scl),
        .sleep_on_bus_low_enable(bl_en), .sleep_on_undervoltage_enable(uv_en),
        .cell_below_sleep_threshold(below), .measure_enable(meas), .sleeping(slp),
        .start_ready(srdy), .power_state(st));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic close_out();
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_st(input fgpm_state_t exp);
        comparisons++;
        if (st !== exp) begin
            fails++;
            $display("ERROR power_state expected %b seen %b", exp, st);
        end
    endtask
    // Bounded wait for a state, then two edges for the other outputs
    task automatic wait_st(input fgpm_state_t exp, input int bound);
        int n;
        for (n = 0; n < bound && st !== exp; n++) @(negedge clk);
        chk_st(exp);
        if (st !== exp) close_out();
        repeat (2) @(negedge clk);
    endtask
    task automatic t_reset();
        chk_st(FGPM_ACTIVE);
        chk("measure_enable", 1'b1, meas);
        chk("sleeping", 1'b0, slp);
        chk("start_ready", 1'b1, srdy);
    endtask
    task automatic t_bus_low();
        bl_en <= 1'b1;
        host.set_lines(1'b0, 1'b0, 1'b0);
        repeat (IDLE - 4) @(negedge clk);
        chk_st(FGPM_ACTIVE);
        wait_st(FGPM_SLEEP_BL, 30);
        repeat (3 * IDLE) @(negedge clk);
        chk("measure_enable", 1'b0, meas);
        chk("sleeping", 1'b1, slp);
        host.set_lines(1'b1, 1'b1, 1'b0);
        wait_st(FGPM_ACTIVE, 10);
        chk("measure_enable", 1'b1, meas);
    endtask
    task automatic t_restart();
        host.set_lines(1'b0, 1'b0, 1'b0);
        repeat (IDLE - 4) @(negedge clk);
        host.set_lines(1'b1, 1'b0, 1'b1);
        repeat (4) @(negedge clk);
        host.set_lines(1'b0, 1'b0, 1'b0);
        repeat (IDLE - 4) @(negedge clk);
        chk_st(FGPM_ACTIVE);
        host.set_lines(1'b1, 1'b1, 1'b1);
        bl_en <= 1'b0;
    endtask
    task automatic t_refuse();
        host.set_lines(1'b0, 1'b0, 1'b0);
        repeat (IDLE + 20) @(negedge clk);
        chk_st(FGPM_ACTIVE);
        host.set_lines(1'b1, 1'b1, 1'b1);
        uv_en <= 1'b1;
        repeat (IDLE + 20) @(negedge clk);
        chk_st(FGPM_ACTIVE);
    endtask
    task automatic t_uv_high();
        below <= 1'b1;
        wait_st(FGPM_SLEEP_UV, IDLE + 30);
        chk("start_ready", 1'b1, srdy);
        chk("measure_enable", 1'b0, meas);
        host.start_stop_start();
        wait_st(FGPM_ACTIVE, 10);
    endtask
    task automatic t_uv_low();
        host.set_lines(1'b0, 1'b0, 1'b0);
        wait_st(FGPM_SLEEP_UV, IDLE + 30);
        chk("start_ready", 1'b0, srdy);
        host.set_lines(1'b1, 1'b1, 1'b1);
        wait_st(FGPM_ACTIVE, 10);
        chk("sleeping", 1'b0, slp);
    endtask
    task automatic t_mid_reset();
        host.set_lines(1'b0, 1'b0, 1'b0);
        wait_st(FGPM_SLEEP_UV, IDLE + 30);
        rst_n <= 1'b0;
        @(negedge clk);
        chk_st(FGPM_ACTIVE);
        chk("sleeping", 1'b0, slp);
        chk("start_ready", 1'b0, srdy);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk("measure_enable", 1'b1, meas);
        chk("start_ready", 1'b1, srdy);
    endtask
    initial begin
        fails = 0;
        comparisons = 0;
        rst_n = 1'b0;
        bl_en = 1'b0;
        uv_en = 1'b0;
        below = 1'b0;
        repeat (8) @(negedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_bus_low();
        t_restart();
        t_refuse();
        t_uv_high();
        t_uv_low();
        t_mid_reset();
        close_out();
    end
endmodule
